// >>> pkg/dic_pkg.sv
`default_nettype none
// ---------------------------------------------------------------
// Shared constants and types
// ---------------------------------------------------------------
package dic_pkg;
	localparam int unsigned CLK_HZ        = 20000000;
	localparam int unsigned NUM_CH        = 8;
	// Filter step in microseconds, and cycles per step (rounded down)
	localparam int unsigned FLT_STEP_US   = 500;
	localparam int unsigned FLT_STEP_CYC  = (CLK_HZ / 1000000) * FLT_STEP_US;
	localparam logic [7:0]  FLT_RESET     = 8'h00;

	// Register offsets
	localparam logic [3:0] REG_CTRL      = 4'h0;
	localparam logic [3:0] REG_FILTER    = 4'h1;
	localparam logic [3:0] REG_MULTI     = 4'h2;
	localparam logic [3:0] REG_SINGLE    = 4'h3;
	localparam logic [3:0] REG_WORD      = 4'h4;
	localparam logic [3:0] REG_IRQ_STAT  = 4'h5;
	localparam logic [3:0] REG_IRQ_EN    = 4'h6;
	localparam logic [3:0] REG_IRQ_CLR   = 4'h7;
	localparam logic [3:0] REG_PINS      = 4'h8;

	// Control field positions
	localparam int unsigned CTRL_CH_LSB    = 0;
	localparam int unsigned CTRL_EVT_BIT   = 3;
	localparam int unsigned CTRL_EDGE_LSB  = 4;
	localparam int unsigned CTRL_INV_BIT   = 6;
	localparam int unsigned CTRL_REQ_BIT   = 7;
	localparam logic [7:0]  CTRL_RESET     = 8'h00;

	// Multi field positions
	localparam int unsigned MULTI_BITS_LSB = 0;
	localparam int unsigned MULTI_LSB_LSB  = 4;
	localparam int unsigned MULTI_GRAY_BIT = 7;
	localparam int unsigned MULTI_INV_BIT  = 8;
	localparam int unsigned MULTI_REQ_BIT  = 9;
	localparam logic [9:0]  MULTI_RESET    = 10'h008;
	localparam logic [3:0]  BITS_MIN       = 4'h6;
	localparam logic [3:0]  BITS_MAX       = 4'h8;

	// Interrupt bit positions
	localparam int unsigned IRQ_SINGLE   = 0;
	localparam int unsigned IRQ_EVENT    = 1;
	localparam int unsigned IRQ_WORD     = 2;
	localparam int unsigned IRQ_W        = 3;

	typedef enum logic [1:0]
	{
		EDGE_RISE = 2'h0,
		EDGE_FALL = 2'h1,
		EDGE_BOTH = 2'h2
	} dic_edge_type;
endpackage : dic_pkg
`default_nettype wire

// >>> pkg/dic_flt_if.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Filter bank carrier
// ---------------------------------------------------------------
interface dic_flt_if;
	logic [7:0] raw;
	logic [7:0] clean;
	logic [7:0] limit;
	logic       tick;
	modport filt (input raw, input limit, input tick, output clean);
	modport user (output raw, output limit, output tick, input clean);
endinterface : dic_flt_if
`default_nettype wire

// >>> design/dic_filter.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Persistence filter for all eight channels, one counter per channel
// ---------------------------------------------------------------
module dic_filter
(
	input  wire logic ref_clk_i,
	input  wire logic reset_n_i,
	input  wire logic clk_en_i,
	dic_flt_if.filt   bus
);
	import dic_pkg::*;

	typedef struct packed
	{
		logic [7:0]      clean;
		logic [7:0][7:0] cnt;
	} dic_flt_type;

	dic_flt_type st_r;
	dic_flt_type st_nxt;

	// Level accepted after limit ticks of stability, the first step partial
	always_comb
	begin
		st_nxt = st_r;
		for (int i = 0; i < 8; i++)
		begin
			if (bus.raw[i] == st_r.clean[i])
				st_nxt.cnt[i] = 8'h00;
			else if (bus.limit == 8'h00 || st_r.cnt[i] >= bus.limit)
			begin
				st_nxt.clean[i] = bus.raw[i];
				st_nxt.cnt[i]   = 8'h00;
			end
			else if (bus.tick)
				st_nxt.cnt[i] = st_r.cnt[i] + 8'h01;
		end
	end

	// Register state
	always_ff @(posedge ref_clk_i)
	begin
		if (!reset_n_i)
			st_r <= '0;
		else if (clk_en_i)
			st_r <= st_nxt;
	end

	assign bus.clean = st_r.clean;
endmodule : dic_filter
`default_nettype wire

// >>> design/dic_decode.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Word assembler and Gray decoder, combinational
// ---------------------------------------------------------------
module dic_decode
(
	input  wire logic [7:0] bits_i,
	input  wire logic [3:0] width_i,
	input  wire logic [2:0] lsb_ch_i,
	input  wire logic       gray_i,
	input  wire logic       inv_i,
	output logic      [7:0] word_o
);
	import dic_pkg::*;

	logic [7:0] rot;
	logic [7:0] sel;
	logic [7:0] mask;
	logic [7:0] bin;

	// Assemble, invert, mask, then decode
	always_comb
	begin
		rot  = 8'((bits_i >> lsb_ch_i) | (bits_i << (4'h8 - {1'b0, lsb_ch_i})));
		mask = 8'((9'h001 << width_i) - 9'h001);
		sel  = (inv_i ? ~rot : rot) & mask;
		bin  = 8'h00;
		for (int i = 7; i >= 0; i--)
		begin
			if (i == 7)
				bin[i] = sel[i];
			else
				bin[i] = bin[i + 1] ^ sel[i];
		end
		word_o = gray_i ? bin : sel;
	end
endmodule : dic_decode
`default_nettype wire

// >>> design/dic_top.sv
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - eight inputs; single function shows the selected channel's clean level.
// - result on request, or refreshed on every qualifying filtered edge of the selected channel in event mode.
// - edge setting picks rising, falling or both for events.
// - filter 0..255 sets persistence, about 0.5 ms per unit.
// - inversion complements the single result; grounded input gives one.
// - an event triggers the whole measurement schedule.
// - multi function samples all bits together, binary or Gray.
// - binary: high is one, word read as unsigned.
// - Gray: reflected Gray decoded to its integer value.
// - word width configurable from six to eight bits.
// - lsb channel setting picks the input for bit zero.
// - optional inversion of sampled bits before conversion.
module dic_top
(
	input  wire logic        ref_clk_i,
	input  wire logic        reset_n_i,
	input  wire logic        clk_en_i,
	input  wire logic [7:0]  pins_i,
	input  wire logic [3:0]  addr_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [15:0] rdata_o,
	output logic             single_bit_result_o,
	output logic      [7:0]  parallel_input_word_o,
	output logic             schedule_trigger_o,
	output logic             irq_o
);
	import dic_pkg::*;

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed
	{
		logic [7:0]       s1;
		logic [7:0]       s2;
		logic [7:0]       s3;
		logic [7:0]       pins;
		logic [7:0]       ctrl;
		logic [7:0]       filt;
		logic [9:0]       multi;
		logic [14:0]      presc;
		logic             tick;
		logic             prev;
		logic             single;
		logic [7:0]       word;
		logic             trig;
		logic [IRQ_W-1:0] stat;
		logic [IRQ_W-1:0] en;
		logic [15:0]      rdata;
	} dic_top_type;

	dic_top_type st_r;
	dic_top_type st_nxt;

	dic_flt_if flt ();
	logic [7:0] dec_word;
	logic       cur;
	logic       edge_hit;
	logic [IRQ_W-1:0] set_bits;
	logic [3:0] width;

	// Clamp word width to the legal range
	function automatic logic [3:0] clamp_bits(input logic [3:0] b);
		if (b < BITS_MIN)
			clamp_bits = BITS_MIN;
		else if (b > BITS_MAX)
			clamp_bits = BITS_MAX;
		else
			clamp_bits = b;
	endfunction : clamp_bits

	// Edge qualification used for events
	function automatic logic edge_ok(input logic [1:0] m, input logic o,
		input logic n);
		if (m == EDGE_RISE)
			edge_ok = !o && n;
		else if (m == EDGE_FALL)
			edge_ok = o && !n;
		else if (m == EDGE_BOTH)
			edge_ok = o != n;
		else
			edge_ok = 1'b0;
	endfunction : edge_ok

	// ---------------------------------------------------------------
	// Sub-blocks
	// ---------------------------------------------------------------
	// Filter sees the synchronised pins
	assign flt.raw   = st_r.pins;
	assign flt.limit = st_r.filt;
	assign flt.tick  = st_r.tick;

	dic_filter u_filter
	(
		.ref_clk_i (ref_clk_i),
		.reset_n_i (reset_n_i),
		.clk_en_i  (clk_en_i),
		.bus       (flt.filt)
	);

	assign width = clamp_bits(st_r.multi[MULTI_BITS_LSB +: 4]);

	dic_decode u_decode
	(
		.bits_i   (flt.clean),
		.width_i  (width),
		.lsb_ch_i (st_r.multi[MULTI_LSB_LSB +: 3]),
		.gray_i   (st_r.multi[MULTI_GRAY_BIT]),
		.inv_i    (st_r.multi[MULTI_INV_BIT]),
		.word_o   (dec_word)
	);

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb
	begin
		st_nxt = st_r;
		// Three stages; change accepted once stages two and three agree
		st_nxt.s1 = pins_i;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		for (int i = 0; i < 8; i++)
		begin
			if (st_r.s2[i] == st_r.s3[i])
				st_nxt.pins[i] = st_r.s3[i];
		end

		// Filter step prescaler
		st_nxt.tick = 1'b0;
		if (st_r.presc >= 15'(FLT_STEP_CYC - 1))
		begin
			st_nxt.presc = '0;
			st_nxt.tick  = 1'b1;
		end
		else
			st_nxt.presc = st_r.presc + 15'h0001;

		cur = flt.clean[st_r.ctrl[CTRL_CH_LSB +: 3]];
		edge_hit = edge_ok(st_r.ctrl[CTRL_EDGE_LSB +: 2], st_r.prev, cur);
		st_nxt.prev = cur;
		set_bits = '0;
		st_nxt.trig = 1'b0;

		if (st_r.ctrl[CTRL_EVT_BIT] && edge_hit)
		begin
			st_nxt.single = cur ^ st_r.ctrl[CTRL_INV_BIT];
			set_bits[IRQ_EVENT] = 1'b1;
			st_nxt.trig = 1'b1;
		end
		else if (st_r.ctrl[CTRL_REQ_BIT])
		begin
			st_nxt.single = cur ^ st_r.ctrl[CTRL_INV_BIT];
			set_bits[IRQ_SINGLE] = 1'b1;
		end
		st_nxt.ctrl[CTRL_REQ_BIT] = 1'b0;

		if (st_r.multi[MULTI_REQ_BIT])
		begin
			st_nxt.word = dec_word;
			set_bits[IRQ_WORD] = 1'b1;
		end
		st_nxt.multi[MULTI_REQ_BIT] = 1'b0;

		// Register writes; request bits self-clear next cycle
		if (wr_i)
		begin
			if (addr_i == REG_CTRL)
				st_nxt.ctrl = wdata_i[7:0];
			else if (addr_i == REG_FILTER)
				st_nxt.filt = wdata_i[7:0];
			else if (addr_i == REG_MULTI)
				st_nxt.multi = wdata_i[9:0];
			else if (addr_i == REG_IRQ_EN)
				st_nxt.en = wdata_i[IRQ_W-1:0];
			else if (addr_i == REG_IRQ_CLR)
				st_nxt.stat = st_r.stat & ~wdata_i[IRQ_W-1:0];
		end
		// Set wins over a same-cycle clear
		st_nxt.stat = st_nxt.stat | set_bits;

		// Read data valid the cycle after the strobe only
		st_nxt.rdata = 16'h0000;
		if (rd_i)
		begin
			if (addr_i == REG_CTRL)
				st_nxt.rdata = {8'h00, st_r.ctrl};
			else if (addr_i == REG_FILTER)
				st_nxt.rdata = {8'h00, st_r.filt};
			else if (addr_i == REG_MULTI)
				st_nxt.rdata = {6'h00, st_r.multi};
			else if (addr_i == REG_SINGLE)
				st_nxt.rdata = {15'h0000, st_r.single};
			else if (addr_i == REG_WORD)
				st_nxt.rdata = {8'h00, st_r.word};
			else if (addr_i == REG_IRQ_STAT)
				st_nxt.rdata = {13'h0000, st_r.stat};
			else if (addr_i == REG_IRQ_EN)
				st_nxt.rdata = {13'h0000, st_r.en};
			else if (addr_i == REG_PINS)
				st_nxt.rdata = {8'h00, flt.clean};
		end
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk_i)
	begin
		if (!reset_n_i)
		begin
			st_r       <= '0;
			st_r.ctrl  <= CTRL_RESET;
			st_r.filt  <= FLT_RESET;
			st_r.multi <= MULTI_RESET;
		end
		else if (clk_en_i)
			st_r <= st_nxt;
	end

	// Outputs straight from flops, except irq: a level gated from the stat and en flops
	assign rdata_o               = st_r.rdata;
	assign single_bit_result_o   = st_r.single;
	assign parallel_input_word_o = st_r.word;
	assign schedule_trigger_o    = st_r.trig;
	assign irq_o                 = |(st_r.stat & st_r.en);
endmodule : dic_top
`default_nettype wire

// >>> sim/dic_contacts.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Switch contacts in front of the input pins
// ---------------------------------------------------------------
module dic_contacts
(
	input  wire logic       ref_clk_i,
	input  wire logic [7:0] level_i,
	input  wire logic       bounce_i,
	output logic      [7:0] pins_o
);
	logic [7:0] last = 8'h00;
	logic [7:0] flip = 8'h00;
	logic [3:0] chat = 4'h0;
	// Changed bits chatter when bounce_i is set, so a filter must hide them
	always_ff @(posedge ref_clk_i)
	begin
		if (level_i != last)
		begin
			chat <= bounce_i ? 4'h9 : 4'h0;
			flip <= level_i ^ last;
		end
		else if (chat != 4'h0)
			chat <= chat - 4'h1;
		last <= level_i;
	end
	assign pins_o = last ^ (chat[0] ? flip : 8'h00);
endmodule : dic_contacts
`default_nettype wire

// >>> sim/dic_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Port checker
// ---------------------------------------------------------------
module dic_top_chk
	import dic_pkg::*;
(
	input  wire logic        ref_clk_i,
	input  wire logic        reset_n_i,
	input  wire logic        clk_en_i,
	input  wire logic [3:0]  addr_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	input  wire logic [15:0] rdata_o,
	input  wire logic        single_bit_result_o,
	input  wire logic [7:0]  parallel_input_word_o,
	input  wire logic        schedule_trigger_o,
	input  wire logic        irq_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);
	logic rk;
	logic wk;
	// Strobes count only while the clock enable runs
	assign rk = rd_i && clk_en_i;
	assign wk = wr_i && clk_en_i;
	AST_RD_SINGLE: assert property (rk && addr_i == REG_SINGLE |=>
		rdata_o == {15'h0, $past(single_bit_result_o)}) else $error("single");
	AST_RD_WORD: assert property (rk && addr_i == REG_WORD |=>
		rdata_o == {8'h0, $past(parallel_input_word_o)}) else $error("word");
	AST_RD_IDLE: assert property (!rd_i && clk_en_i |=>
		rdata_o == 16'h0) else $error("rdata not idle");
	AST_UNMAPPED: assert property (rk && addr_i > REG_PINS |=>
		rdata_o == 16'h0) else $error("unmapped read");
	AST_FILT_RB: assert property (wk && addr_i == REG_FILTER ##2
		rk && addr_i == REG_FILTER |=> rdata_o == {8'h0, $past(wdata_i[7:0], 3)})
		else $error("filter readback");
	AST_IRQ_MASK: assert property (wk && addr_i == REG_IRQ_EN
		&& wdata_i[2:0] == 3'h0 |=> !irq_o) else $error("masked irq");
	AST_TRIG_PULSE: assert property (schedule_trigger_o |=>
		!schedule_trigger_o) else $error("trigger too long");
	AST_FREEZE: assert property (!clk_en_i |=> $stable(rdata_o)
		&& $stable(single_bit_result_o) && $stable(parallel_input_word_o))
		else $error("frozen outputs moved");
endmodule : dic_top_chk
bind dic_top dic_top_chk u_chk (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
	.clk_en_i(clk_en_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
	.rd_i(rd_i), .rdata_o(rdata_o), .single_bit_result_o(single_bit_result_o),
	.parallel_input_word_o(parallel_input_word_o),
	.schedule_trigger_o(schedule_trigger_o), .irq_o(irq_o));
`default_nettype wire

// >>> sim/dic_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dic_top_tb;
	import dic_pkg::*;
	logic        ref_clk_i = 1'b0;
	logic        reset_n_i = 1'b0;
	logic        clk_en_i  = 1'b1;
	logic [7:0]  lvl       = 8'h00;
	logic        bounce    = 1'b0;
	logic [7:0]  pins_i;
	logic [3:0]  addr_i    = 4'h0;
	logic [15:0] wdata_i   = 16'h0;
	logic        wr_i      = 1'b0;
	logic        rd_i      = 1'b0;
	logic [15:0] rdata_o;
	logic        single_bit_result_o;
	logic [7:0]  parallel_input_word_o;
	logic        schedule_trigger_o;
	logic        irq_o;
	logic [15:0] d;
	int          bad_count = 0;
	int          compares  = 0;
	int          trig      = 0;
	// Multi cases: pins, config with request, expected word
	logic [7:0]  mp [7] = '{8'h0a, 8'h03, 8'h06, 8'h04, 8'h0c, 8'hc0, 8'hfc};
	logic [9:0]  mc [7] = '{10'h208, 10'h288, 10'h288, 10'h288, 10'h226,
		10'h206, 10'h388};
	logic [7:0]  mx [7] = '{8'd10, 8'd2, 8'd4, 8'd7, 8'd3, 8'd0, 8'd2};
	int          ne [4] = '{1, 1, 2, 0};
	dic_top DUT (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
		.clk_en_i(clk_en_i), .pins_i(pins_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.single_bit_result_o(single_bit_result_o),
		.parallel_input_word_o(parallel_input_word_o),
		.schedule_trigger_o(schedule_trigger_o), .irq_o(irq_o));
	dic_contacts u_sw (.ref_clk_i(ref_clk_i), .level_i(lvl),
		.bounce_i(bounce), .pins_o(pins_i));
	always #25 ref_clk_i = ~ref_clk_i;
	// Count trigger pulses
	always @(posedge ref_clk_i)
		if (schedule_trigger_o === 1'b1)
			trig <= trig + 1;
	// ---------------------------------------------------------------
	// Bus and check tasks
	// ---------------------------------------------------------------
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge ref_clk_i);
		addr_i  <= a;
		wdata_i <= v;
		wr_i    <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask : rd
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		compares++;
		if (g !== e)
		begin
			bad_count++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic wt(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask : wt
	task automatic pin(input logic [7:0] v);
		@(posedge ref_clk_i);
		lvl <= v;
	endtask : pin
	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_regs();
		rd(REG_MULTI);
		chk(d, 16'h0008);
		wr(REG_FILTER, 16'h00a5);
		rd(REG_FILTER);
		chk(d, 16'h00a5);
		wr(REG_FILTER, 16'h0000);
		rd(4'hc);
		chk(d, 16'h0000);
		@(posedge ref_clk_i);
		clk_en_i <= 1'b0;
		wt(4);
		@(posedge ref_clk_i);
		clk_en_i <= 1'b1;
		wr(REG_IRQ_EN, 16'h0000);
		wr(REG_CTRL, 16'h0080);
		wt(3);
		chk(16'(irq_o), 16'h0);
		rd(REG_IRQ_STAT);
		chk(d, 16'h0001);
		wr(REG_IRQ_EN, 16'h0001);
		wt(1);
		chk(16'(irq_o), 16'h1);
		wr(REG_IRQ_CLR, 16'h0001);
		wt(1);
		chk(16'(irq_o), 16'h0);
		$display("regs done");
	endtask : t_regs
	task automatic t_single();
		pin(8'h96);
		wt(8);
		for (int c = 0; c < 8; c++)
			for (int v = 0; v < 2; v++)
			begin
				wr(REG_CTRL, 16'(8'h80 | v << 6 | c));
				wt(3);
				chk(16'(single_bit_result_o), 16'(lvl[c] ^ v[0]));
			end
		$display("single done");
	endtask : t_single
	task automatic t_multi();
		wr(REG_IRQ_EN, 16'h0004);
		for (int i = 0; i < 7; i++)
		begin
			pin(mp[i]);
			wt(8);
			wr(REG_MULTI, 16'(mc[i]));
			wt(3);
			chk(16'(parallel_input_word_o), 16'(mx[i]));
			chk(16'(irq_o), 16'h1);
			wr(REG_IRQ_CLR, 16'h0004);
			rd(REG_WORD);
			chk(d, 16'(mx[i]));
			chk(16'(irq_o), 16'h0);
		end
		$display("multi done");
	endtask : t_multi
	task automatic t_event();
		int n;
		pin(8'h00);
		wt(8);
		for (int e = 0; e < 4; e++)
		begin
			wr(REG_CTRL, 16'(e == 3 ? 8'h00 : 8'h08 | e << 4));
			n = trig;
			pin(8'h01);
			wt(10);
			if (e == 2)
				chk(16'(single_bit_result_o), 16'h1);
			pin(8'h00);
			wt(10);
			chk(16'(trig - n), 16'(ne[e]));
		end
		$display("event done");
	endtask : t_event
	task automatic t_filter();
		wr(REG_FILTER, 16'h0002);
		@(posedge ref_clk_i);
		bounce <= 1'b1;
		lvl    <= 8'h80;
		// Under one whole step: prescaler phase cannot matter yet
		wt(9000);
		rd(REG_PINS);
		chk(d, 16'h0000);
		// Past two whole steps plus a partial first step
		wt(23000);
		rd(REG_PINS);
		chk(d, 16'h0080);
		$display("filter done");
	endtask : t_filter
	task automatic report_and_stop();
		$display("compares %0d bad %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop
	// Hang guard, well past the filter wait
	initial
	begin
		repeat (60000) @(posedge ref_clk_i);
		bad_count++;
		report_and_stop();
	end
	initial
	begin
		repeat (8) @(posedge ref_clk_i);
		reset_n_i <= 1'b1;
		t_regs();
		t_single();
		t_multi();
		t_event();
		t_filter();
		report_and_stop();
	end
endmodule : dic_top_tb
`default_nettype wire
